// ===== design/gpef_defs.svh
// offsets, field positions and reset values for the port e/f block
`ifndef GPEF_DEFS_SVH
`define GPEF_DEFS_SVH
`define GPEF_ADDR_W 16
`define GPEF_OFS_E_DATA 16'h0008
`define GPEF_OFS_F_DATA 16'h0009
`define GPEF_OFS_E_DIR 16'h000C
`define GPEF_OFS_F_DIR 16'h000D
`define GPEF_OFS_ALT_CTRL 16'h000E
`define GPEF_OFS_TIM_SEL 16'h000F
`define GPEF_E_DIR_RST 8'h00
`define GPEF_F_DIR_RST 7'h00
`define GPEF_ALT_RST 8'h00
`define GPEF_TIM_RST 8'h00
`define GPEF_ALT_SPI_EN 0
`define GPEF_ALT_SPI_MST 1
`define GPEF_ALT_MODF_EN 2
`define GPEF_ALT_SCI_EN 3
`define GPEF_PIN_SCK 7
`define GPEF_PIN_MOSI 6
`define GPEF_PIN_MISO 5
`define GPEF_PIN_SS 4
`define GPEF_PIN_RXD 1
`define GPEF_PIN_TXD 0
`endif

// ===== design/gpef_pkg.sv
// types for the port e/f block
package gpef_pkg;
  typedef struct packed {
    logic [15:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } gpef_bus_s;
  typedef struct packed {
    logic sck_out;
    logic mosi_out;
    logic miso_out;
    logic sci_txd;
    logic [1:0] tim_a_e_out;
    logic [3:0] tim_a_f_out;
    logic [1:0] tim_b_out;
  } gpef_periph_s;
  typedef struct packed {
    logic sck_in;
    logic mosi_in;
    logic miso_in;
    logic ss_in;
    logic sci_rxd;
    logic [1:0] tim_a_e_in;
    logic [3:0] tim_a_f_in;
    logic [1:0] tim_b_in;
  } gpef_periph_in_s;
endpackage : gpef_pkg

// ===== design/gpef_ports.sv
// port e and port f data latches, directions and pin sharing
`timescale 1ns/1ns
`include "gpef_defs.svh"
// How it works
// RL1: direction 1 drives pin, 0 floats it
// RL2: reset clears port e directions
// RL3: reset clears port f directions
// RL4: reset leaves port f latch alone
// RL5: port e read mixes latch and pin
// RL6: port f read mixes latch and pin
// RL7: data writes always update latch
// RL8: e7 is spi clock when enabled
// RL9: e6 mosi, e5 miso when spi enabled
// RL10: e4 slave select unless off or master-nofault
// RL11: claimed port e pins ignore direction when driving; reads still mix by direction
// RL12: e3,e2 are timer a channels 1,0
// RL13: e1 receive, e0 transmit when sci enabled
// RL14: f3..f0 are timer a channels 5..2
// RL15: f5,f4 are timer b channels 1,0
// RL16: claimed port f pins ignore direction when driving; reads still mix by direction
// RL17: software writes data before direction
// RL18: accesses act on the clock edge
module gpef_ports (
  input wire logic clk_sys,
  input wire logic rst,
  input wire gpef_pkg::gpef_bus_s bus,
  output logic [7:0] rdata,
  input wire logic [7:0] pin_e_in,
  output logic [7:0] pin_e_out,
  output logic [7:0] pin_e_oe_n,
  input wire logic [6:0] pin_f_in,
  output logic [6:0] pin_f_out,
  output logic [6:0] pin_f_oe_n,
  input wire gpef_pkg::gpef_periph_s periph,
  output gpef_pkg::gpef_periph_in_s periph_in
);
  logic [7:0] e_sync1_reg;
  logic [7:0] e_pin_reg;
  logic [6:0] f_sync1_reg;
  logic [6:0] f_pin_reg;
  logic [7:0] port_e_data_latch_reg;
  logic [6:0] port_f_data_latch_reg;
  logic [7:0] port_e_direction_reg;
  logic [6:0] port_f_direction_reg;
  logic [7:0] alt_ctrl_reg;
  logic [7:0] tim_sel_reg;
  logic [7:0] rdata_next;
  logic spi_on;
  logic spi_master;
  logic ss_used;
  logic sci_on;
  logic [7:0] e_claim;
  logic [7:0] e_alt_oe;
  logic [7:0] e_alt_val;
  logic [6:0] f_claim;
  logic [6:0] f_alt_oe;
  logic [6:0] f_alt_val;
  logic wr_e;
  logic wr_f;

  // pins pass two flops before any logic reads them
  always_ff @(posedge clk_sys) begin
    e_sync1_reg <= pin_e_in;
    e_pin_reg <= e_sync1_reg;
    f_sync1_reg <= pin_f_in;
    f_pin_reg <= f_sync1_reg;
  end

  assign wr_e = bus.wr && (bus.addr == `GPEF_OFS_E_DATA);
  assign wr_f = bus.wr && (bus.addr == `GPEF_OFS_F_DATA);

  // latches have no reset
  always_ff @(posedge clk_sys) begin
    if (wr_e) begin // [RL7] [RL18]
      port_e_data_latch_reg <= bus.wdata;
    end
    if (wr_f) begin // [RL7] [RL4]
      port_f_data_latch_reg <= bus.wdata[6:0];
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      port_e_direction_reg <= `GPEF_E_DIR_RST; // [RL2]
      port_f_direction_reg <= `GPEF_F_DIR_RST; // [RL3]
    end else if (bus.wr) begin
      if (bus.addr == `GPEF_OFS_E_DIR) begin // [RL18]
        port_e_direction_reg <= bus.wdata;
      end
      if (bus.addr == `GPEF_OFS_F_DIR) begin
        port_f_direction_reg <= bus.wdata[6:0];
      end
    end
  end

  // stand-in for the peripheral enables: spi, master, mode fault, sci; timer pin claims
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      alt_ctrl_reg <= `GPEF_ALT_RST;
      tim_sel_reg <= `GPEF_TIM_RST;
    end else if (bus.wr) begin
      if (bus.addr == `GPEF_OFS_ALT_CTRL) begin
        alt_ctrl_reg <= {4'h0, bus.wdata[3:0]};
      end
      if (bus.addr == `GPEF_OFS_TIM_SEL) begin
        tim_sel_reg <= bus.wdata;
      end
    end
  end

  assign spi_on = alt_ctrl_reg[`GPEF_ALT_SPI_EN];
  assign spi_master = alt_ctrl_reg[`GPEF_ALT_SPI_MST];
  assign sci_on = alt_ctrl_reg[`GPEF_ALT_SCI_EN];
  assign ss_used = spi_on && !(spi_master && !alt_ctrl_reg[`GPEF_ALT_MODF_EN]); // [RL10]

  always_comb begin
    e_claim = 8'h00;
    e_alt_oe = 8'h00;
    e_alt_val = 8'h00;
    e_claim[7] = spi_on; // [RL8]
    e_alt_oe[7] = spi_master;
    e_alt_val[7] = periph.sck_out;
    e_claim[6] = spi_on; // [RL9]
    e_alt_oe[6] = spi_master;
    e_alt_val[6] = periph.mosi_out;
    e_claim[5] = spi_on;
    e_alt_oe[5] = !spi_master;
    e_alt_val[5] = periph.miso_out;
    e_claim[4] = ss_used; // [RL10]
    e_claim[3:2] = tim_sel_reg[1:0]; // [RL12]
    e_alt_oe[3:2] = tim_sel_reg[1:0];
    e_alt_val[3:2] = periph.tim_a_e_out;
    e_claim[1] = sci_on; // [RL13]
    e_claim[0] = sci_on;
    e_alt_oe[0] = 1'b1;
    e_alt_val[0] = periph.sci_txd;
    f_claim = {1'b0, tim_sel_reg[7:2]}; // [RL14] [RL15]
    f_alt_oe = f_claim;
    f_alt_val = {1'b0, periph.tim_b_out, periph.tim_a_f_out};
  end

  always_comb begin
    for (int i = 0; i < 8; i++) begin
      if (e_claim[i]) begin // [RL11]
        pin_e_oe_n[i] = !e_alt_oe[i];
        pin_e_out[i] = e_alt_val[i];
      end else begin // [RL1]
        pin_e_oe_n[i] = !port_e_direction_reg[i];
        pin_e_out[i] = port_e_data_latch_reg[i];
      end
    end
    for (int j = 0; j < 7; j++) begin
      if (f_claim[j]) begin // [RL16]
        pin_f_oe_n[j] = !f_alt_oe[j];
        pin_f_out[j] = f_alt_val[j];
      end else begin // [RL1]
        pin_f_oe_n[j] = !port_f_direction_reg[j];
        pin_f_out[j] = port_f_data_latch_reg[j];
      end
    end
  end

  always_comb begin
    periph_in.sck_in = e_pin_reg[`GPEF_PIN_SCK];
    periph_in.mosi_in = e_pin_reg[`GPEF_PIN_MOSI];
    periph_in.miso_in = e_pin_reg[`GPEF_PIN_MISO];
    periph_in.ss_in = ss_used ? e_pin_reg[`GPEF_PIN_SS] : 1'b1;
    periph_in.sci_rxd = sci_on ? e_pin_reg[`GPEF_PIN_RXD] : 1'b1;
    periph_in.tim_a_e_in = e_pin_reg[3:2];
    periph_in.tim_a_f_in = f_pin_reg[3:0];
    periph_in.tim_b_in = f_pin_reg[5:4];
  end

  always_comb begin
    rdata_next = 8'h00;
    case (bus.addr)
      `GPEF_OFS_E_DATA: rdata_next = (port_e_direction_reg & port_e_data_latch_reg)
        | (~port_e_direction_reg & e_pin_reg); // [RL5] [RL11]
      `GPEF_OFS_F_DATA: rdata_next = {1'b0, (port_f_direction_reg & port_f_data_latch_reg)
        | (~port_f_direction_reg & f_pin_reg)}; // [RL6] [RL16]
      `GPEF_OFS_E_DIR: rdata_next = port_e_direction_reg;
      `GPEF_OFS_F_DIR: rdata_next = {1'b0, port_f_direction_reg};
      `GPEF_OFS_ALT_CTRL: rdata_next = alt_ctrl_reg;
      `GPEF_OFS_TIM_SEL: rdata_next = tim_sel_reg;
      default: rdata_next = 8'h00;
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      rdata <= 8'h00;
    end else if (bus.rd) begin // [RL18]
      rdata <= rdata_next;
    end else begin
      rdata <= 8'h00;
    end
  end

  // bus access shapes used by the read and write checks
  sequence s_read_e;
    bus.rd && bus.addr == `GPEF_OFS_E_DATA;
  endsequence
  sequence s_read_f;
    bus.rd && bus.addr == `GPEF_OFS_F_DATA;
  endsequence
  sequence s_read_edir;
    bus.rd && bus.addr == `GPEF_OFS_E_DIR;
  endsequence
  sequence s_read_fdir;
    bus.rd && bus.addr == `GPEF_OFS_F_DIR;
  endsequence
  sequence s_read_hole;
    bus.rd && !(bus.addr inside {`GPEF_OFS_E_DATA, `GPEF_OFS_F_DATA, `GPEF_OFS_E_DIR,
      `GPEF_OFS_F_DIR, `GPEF_OFS_ALT_CTRL, `GPEF_OFS_TIM_SEL});
  endsequence
  sequence s_write_edir;
    bus.wr && bus.addr == `GPEF_OFS_E_DIR;
  endsequence
  sequence s_write_fdir;
    bus.wr && bus.addr == `GPEF_OFS_F_DIR;
  endsequence

  a_dir_e_reset: assert property (@(posedge clk_sys) // [RL2]
    rst |=> port_e_direction_reg == 8'h00)
    else $error("port e direction not cleared");
  a_dir_f_reset: assert property (@(posedge clk_sys) // [RL3]
    rst |=> port_f_direction_reg == 7'h00)
    else $error("port f direction not cleared");
  a_reset_float: assert property (@(posedge clk_sys) // [RL2] [RL3]
    rst |=> (&pin_e_oe_n) && (&pin_f_oe_n))
    else $error("pin driven after reset");
  a_alt_reset: assert property (@(posedge clk_sys) // [RL11]
    rst |=> alt_ctrl_reg == 8'h00 && tim_sel_reg == 8'h00)
    else $error("pin sharing not cleared");
  a_latch_keep: assert property (@(posedge clk_sys) // [RL4]
    rst && !wr_f |=> $stable(port_f_data_latch_reg))
    else $error("port f latch changed by reset");
  a_latch_write: assert property (@(posedge clk_sys) disable iff (rst) // [RL7]
    wr_e |=> port_e_data_latch_reg == $past(bus.wdata))
    else $error("port e latch not written");
  a_latch_f_write: assert property (@(posedge clk_sys) disable iff (rst) // [RL7]
    wr_f |=> port_f_data_latch_reg == $past(bus.wdata[6:0]))
    else $error("port f latch not written");
  a_dir_e_write: assert property (@(posedge clk_sys) disable iff (rst) // [RL18]
    s_write_edir |=> port_e_direction_reg == $past(bus.wdata))
    else $error("port e direction not written");
  a_dir_f_write: assert property (@(posedge clk_sys) disable iff (rst) // [RL18]
    s_write_fdir |=> port_f_direction_reg == $past(bus.wdata[6:0]))
    else $error("port f direction not written");
  a_gpio_drive: assert property (@(posedge clk_sys) disable iff (rst) // [RL1]
    !alt_ctrl_reg[0] && !tim_sel_reg[7] |-> pin_e_oe_n[7] == !port_e_direction_reg[7]
    && pin_f_oe_n[5] == !port_f_direction_reg[5])
    else $error("gpio direction not applied");
  a_gpio_e_dir: assert property (@(posedge clk_sys) disable iff (rst) // [RL1] [RL11]
    (pin_e_oe_n | e_claim) == (~port_e_direction_reg | e_claim))
    else $error("port e unclaimed direction wrong");
  a_gpio_f_dir: assert property (@(posedge clk_sys) disable iff (rst) // [RL1] [RL16]
    (pin_f_oe_n | f_claim) == (~port_f_direction_reg | f_claim))
    else $error("port f unclaimed direction wrong");
  a_f_top_gpio: assert property (@(posedge clk_sys) disable iff (rst) // [RL16]
    pin_f_oe_n[6] == !port_f_direction_reg[6])
    else $error("port f bit 6 not gpio");
  a_read_e_mix: assert property (@(posedge clk_sys) disable iff (rst) // [RL5]
    s_read_e |=> rdata == (($past(port_e_direction_reg) & $past(port_e_data_latch_reg))
    | (~$past(port_e_direction_reg) & $past(e_pin_reg))))
    else $error("port e read wrong");
  a_read_f_mix: assert property (@(posedge clk_sys) disable iff (rst) // [RL6]
    s_read_f |=> rdata[6:0] == (($past(port_f_direction_reg)
    & $past(port_f_data_latch_reg)) | (~$past(port_f_direction_reg) & $past(f_pin_reg))))
    else $error("port f read wrong");
  a_read_f_top: assert property (@(posedge clk_sys) disable iff (rst) // [RL6]
    s_read_f |=> !rdata[7])
    else $error("port f top bit not zero");
  a_read_e_dir: assert property (@(posedge clk_sys) disable iff (rst) // [RL2]
    s_read_edir |=> rdata == $past(port_e_direction_reg))
    else $error("port e direction read wrong");
  a_read_f_dir: assert property (@(posedge clk_sys) disable iff (rst) // [RL3]
    s_read_fdir |=> rdata == {1'b0, $past(port_f_direction_reg)})
    else $error("port f direction read wrong");
  a_read_hole: assert property (@(posedge clk_sys) disable iff (rst) // [RL18]
    s_read_hole |=> rdata == 8'h00)
    else $error("unmapped read not zero");
  a_rdata_idle: assert property (@(posedge clk_sys) disable iff (rst) // [RL18]
    !bus.rd |=> rdata == 8'h00)
    else $error("read data stands too long");
  a_sck_master: assert property (@(posedge clk_sys) disable iff (rst) // [RL8]
    spi_on && spi_master |-> !pin_e_oe_n[7] && pin_e_out[7] == periph.sck_out)
    else $error("spi clock not driven");
  a_sck_slave: assert property (@(posedge clk_sys) disable iff (rst) // [RL8] [RL9]
    spi_on && !spi_master |-> pin_e_oe_n[7] && pin_e_oe_n[6] && !pin_e_oe_n[5]
    && pin_e_out[5] == periph.miso_out)
    else $error("spi slave pins wrong");
  a_mosi_master: assert property (@(posedge clk_sys) disable iff (rst) // [RL9]
    spi_on && spi_master |-> !pin_e_oe_n[6] && pin_e_out[6] == periph.mosi_out
    && pin_e_oe_n[5])
    else $error("spi master data pins wrong");
  a_ss_input: assert property (@(posedge clk_sys) disable iff (rst) // [RL10]
    spi_on && !spi_master |-> pin_e_oe_n[4])
    else $error("slave select driven in slave mode");
  a_ss_modf: assert property (@(posedge clk_sys) disable iff (rst) // [RL10]
    spi_on && spi_master && alt_ctrl_reg[`GPEF_ALT_MODF_EN] |-> pin_e_oe_n[4])
    else $error("slave select driven with mode fault on");
  a_ss_idle: assert property (@(posedge clk_sys) disable iff (rst) // [RL10]
    !ss_used |-> periph_in.ss_in)
    else $error("slave select not idle");
  a_sci_tx: assert property (@(posedge clk_sys) disable iff (rst) // [RL13]
    sci_on |-> !pin_e_oe_n[0] && pin_e_oe_n[1] && pin_e_out[0] == periph.sci_txd)
    else $error("sci pins wrong");
  a_rxd_idle: assert property (@(posedge clk_sys) disable iff (rst) // [RL13]
    !sci_on |-> periph_in.sci_rxd)
    else $error("sci receive not idle");
  a_tim_e0: assert property (@(posedge clk_sys) disable iff (rst) // [RL12]
    tim_sel_reg[0] |-> !pin_e_oe_n[2] && pin_e_out[2] == periph.tim_a_e_out[0])
    else $error("timer a channel 0 not claimed");
  a_tim_e1: assert property (@(posedge clk_sys) disable iff (rst) // [RL12]
    tim_sel_reg[1] |-> !pin_e_oe_n[3] && pin_e_out[3] == periph.tim_a_e_out[1])
    else $error("timer a channel 1 not claimed");
  a_tim_f: assert property (@(posedge clk_sys) disable iff (rst) // [RL14]
    tim_sel_reg[2] |-> !pin_f_oe_n[0] && pin_f_out[0] == periph.tim_a_f_out[0])
    else $error("timer a pin not claimed");
  a_tim_f3: assert property (@(posedge clk_sys) disable iff (rst) // [RL14]
    tim_sel_reg[5] |-> !pin_f_oe_n[3] && pin_f_out[3] == periph.tim_a_f_out[3])
    else $error("timer a channel 5 not claimed");
  a_tim_b0: assert property (@(posedge clk_sys) disable iff (rst) // [RL15]
    tim_sel_reg[6] |-> !pin_f_oe_n[4] && pin_f_out[4] == periph.tim_b_out[0])
    else $error("timer b channel 0 not claimed");
  a_tim_b1: assert property (@(posedge clk_sys) disable iff (rst) // [RL15]
    tim_sel_reg[7] |-> !pin_f_oe_n[5] && pin_f_out[5] == periph.tim_b_out[1])
    else $error("timer b channel 1 not claimed");
  a_sync_sck: assert property (@(posedge clk_sys) disable iff (rst) // [RL8]
    periph_in.sck_in == $past(pin_e_in[7], 2))
    else $error("spi clock input lag wrong");
  a_sync_tim_b: assert property (@(posedge clk_sys) disable iff (rst) // [RL15]
    periph_in.tim_b_in == $past(pin_f_in[5:4], 2))
    else $error("timer b input lag wrong");
endmodule : gpef_ports

// ===== verif/gpef_pads.sv
// pad model: outside drivers and the resolved level of each port pin
`timescale 1ns/1ns
module gpef_pads (
  input wire logic [7:0] ext_e,
  input wire logic [6:0] ext_f,
  input wire logic [7:0] pin_e_out,
  input wire logic [7:0] pin_e_oe_n,
  input wire logic [6:0] pin_f_out,
  input wire logic [6:0] pin_f_oe_n,
  output logic [7:0] pin_e_in,
  output logic [6:0] pin_f_in
);
  // the outside driver backs off wherever the chip drives, so no contention
  assign pin_e_in = (~pin_e_oe_n & pin_e_out) | (pin_e_oe_n & ext_e);
  assign pin_f_in = (~pin_f_oe_n & pin_f_out) | (pin_f_oe_n & ext_f);
endmodule : gpef_pads

// ===== verif/gpef_ports_tb.sv
// self-checking bench for the port e/f block
`timescale 1ns/1ns
`include "gpef_defs.svh"
module gpef_ports_tb;
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  gpef_pkg::gpef_bus_s bus = '0;
  gpef_pkg::gpef_periph_s periph = '0;
  gpef_pkg::gpef_periph_in_s periph_in;
  logic [7:0] rdata, pin_e_in, pin_e_out, pin_e_oe_n, ext_e = 8'h00;
  logic [6:0] pin_f_in, pin_f_out, pin_f_oe_n, ext_f = 7'h00;
  logic [7:0] m_le, m_de, m_alt, m_tim, x_drv, x_out, pad;
  logic [6:0] m_lf, m_df;
  logic [12:0] x_in;
  logic [31:0] seed = 32'hED67E1F8;
  logic [31:0] r;
  int error_cnt = 0;
  int cmp_count = 0;
  always #50 clk_sys = ~clk_sys;
  gpef_ports dut (.clk_sys(clk_sys), .rst(rst), .bus(bus), .rdata(rdata),
    .pin_e_in(pin_e_in), .pin_e_out(pin_e_out), .pin_e_oe_n(pin_e_oe_n),
    .pin_f_in(pin_f_in), .pin_f_out(pin_f_out), .pin_f_oe_n(pin_f_oe_n),
    .periph(periph), .periph_in(periph_in));
  gpef_pads pads (.ext_e(ext_e), .ext_f(ext_f), .pin_e_out(pin_e_out),
    .pin_e_oe_n(pin_e_oe_n), .pin_f_out(pin_f_out), .pin_f_oe_n(pin_f_oe_n),
    .pin_e_in(pin_e_in), .pin_f_in(pin_f_in));
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : rnd
  task automatic finish_test();
    $display("errors %0d compares %0d", error_cnt, cmp_count);
    if (error_cnt == 0 && cmp_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : finish_test
  task automatic chk_rd(input logic [7:0] g, input logic [7:0] e);
    cmp_count++;
    if (g !== e) begin
      error_cnt++;
      $display("BAD %0t read got %h exp %h", $time, g, e);
    end
  endtask : chk_rd
  task automatic chk_pin(input logic [7:0] g, input logic [7:0] e);
    cmp_count++;
    if (g !== e) begin
      error_cnt++;
      $display("BAD %0t pins got %h exp %h", $time, g, e);
    end
  endtask : chk_pin
  task automatic chk_in(input logic [12:0] g, input logic [12:0] e);
    cmp_count++;
    if (g !== e) begin
      error_cnt++;
      $display("BAD %0t periph in got %h exp %h", $time, g, e);
    end
  endtask : chk_in
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk_sys);
    bus <= '0;
    @(posedge clk_sys);
  endtask : wr
  task automatic rd_chk(input logic [15:0] a, input logic [7:0] e);
    bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge clk_sys);
    bus <= '0;
    #1;
    chk_rd(rdata, e);
    @(posedge clk_sys);
  endtask : rd_chk
  // expected drive mask and drive value of port e
  task automatic model_e();
    x_drv = m_de;
    x_out = m_le;
    if (m_alt[0]) begin
      x_drv[7:5] = m_alt[1] ? 3'h6 : 3'h1;
      x_out[7:5] = {periph.sck_out, periph.mosi_out, periph.miso_out};
      if (!m_alt[1] || m_alt[2]) x_drv[4] = 1'b0;
    end
    if (m_alt[3]) begin
      x_drv[1:0] = 2'h1;
      x_out[0] = periph.sci_txd;
    end
    for (int i = 0; i < 2; i++) begin
      if (m_tim[i]) begin
        x_drv[i + 2] = 1'b1;
        x_out[i + 2] = periph.tim_a_e_out[i];
      end
    end
  endtask : model_e
  task automatic model_f();
    x_drv = {1'b0, m_df};
    x_out = {1'b0, m_lf};
    for (int i = 0; i < 4; i++) begin
      if (m_tim[i + 2]) begin
        x_drv[i] = 1'b1;
        x_out[i] = periph.tim_a_f_out[i];
      end
    end
    for (int i = 0; i < 2; i++) begin
      if (m_tim[i + 6]) begin
        x_drv[i + 4] = 1'b1;
        x_out[i + 4] = periph.tim_b_out[i];
      end
    end
  endtask : model_f
  task automatic check_all();
    #1;
    model_e();
    chk_pin(pin_e_oe_n, ~x_drv);
    chk_pin(pin_e_out & x_drv, x_out & x_drv);
    pad = (x_drv & x_out) | (~x_drv & ext_e);
    x_in[12:6] = {pad[7:5], (m_alt[0] && !(m_alt[1] && !m_alt[2])) ? pad[4] : 1'b1,
      m_alt[3] ? pad[1] : 1'b1, pad[3:2]};
    model_f();
    chk_pin({1'b1, pin_f_oe_n}, ~x_drv);
    chk_pin({1'b0, pin_f_out} & x_drv, x_out & x_drv);
    @(posedge clk_sys);
    rd_chk(`GPEF_OFS_E_DATA, (m_de & m_le) | (~m_de & pad));
    pad = (x_drv & x_out) | (~x_drv & {1'b0, ext_f});
    x_in[5:0] = {pad[3:0], pad[5:4]};
    chk_in(periph_in, x_in);
    rd_chk(`GPEF_OFS_F_DATA, {1'b0, m_df & m_lf} | (~{1'b0, m_df} & pad));
    rd_chk(`GPEF_OFS_E_DIR, m_de);
    rd_chk(`GPEF_OFS_F_DIR, {1'b0, m_df});
    rd_chk(`GPEF_OFS_ALT_CTRL, m_alt);
    rd_chk(`GPEF_OFS_TIM_SEL, m_tim);
  endtask : check_all
  task automatic do_reset();
    rst <= 1'b1;
    repeat (4) @(posedge clk_sys);
    rst <= 1'b0;
    @(posedge clk_sys);
    m_de = 8'h00;
    m_df = 7'h00;
    m_alt = 8'h00;
    m_tim = 8'h00;
    check_all();
  endtask : do_reset
  initial begin
    repeat (5000) @(posedge clk_sys);
    error_cnt++;
    finish_test();
  end
  initial begin
    do_reset();
    rd_chk(16'h0010, 8'h00);
    for (int n = 0; n < 40; n++) begin
      r = rnd();
      periph <= r[11:0];
      ext_e <= r[19:12];
      ext_f <= r[26:20];
      r = rnd();
      m_le = r[7:0];
      m_lf = r[14:8];
      m_de = r[23:16];
      m_df = r[30:24];
      m_alt = {4'h0, n[3:0]};
      m_tim = (n > 15) ? (r[31:24] ^ r[7:0]) : 8'h00;
      wr(`GPEF_OFS_E_DATA, m_le);
      wr(`GPEF_OFS_F_DATA, {1'b0, m_lf});
      wr(`GPEF_OFS_E_DIR, m_de);
      wr(`GPEF_OFS_F_DIR, {1'b0, m_df});
      wr(`GPEF_OFS_ALT_CTRL, m_alt);
      wr(`GPEF_OFS_TIM_SEL, m_tim);
      repeat (3) @(posedge clk_sys);
      check_all();
    end
    do_reset();
    m_df = 7'h7F;
    wr(`GPEF_OFS_F_DIR, 8'h7F);
    repeat (3) @(posedge clk_sys);
    check_all();
    finish_test();
  end
endmodule : gpef_ports_tb
